// ==== verilog/uss_pkg.sv ====
// Shared constants and types for the universal shift/storage register
`default_nettype none
package uss_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned USS_WIDTH       = 8;
    localparam int unsigned USS_BUF_DEPTH   = 2;
    // ==========================================================
    // Bit positions of the register ends
    localparam int unsigned USS_LOW_BIT     = 0;
    localparam int unsigned USS_HIGH_BIT    = USS_WIDTH - 1;
    // ==========================================================
    // Reset value of the register
    localparam logic [USS_WIDTH-1:0] USS_CLEAR_VAL = 8'h00;
    // ==========================================================
    // Mode encoding: {mode_select_high, mode_select_low}
    localparam logic [1:0] USS_MODE_HOLD    = 2'h0;
    localparam logic [1:0] USS_MODE_SHR     = 2'h1;
    localparam logic [1:0] USS_MODE_SHL     = 2'h2;
    localparam logic [1:0] USS_MODE_LOAD    = 2'h3;
    // Reset variant selection values
    localparam logic       USS_VARIANT_ASYNC = 1'b0;
    localparam logic       USS_VARIANT_SYNC  = 1'b1;
    // Operation type decoded from the selects
    typedef enum logic [1:0] {
        USS_OP_HOLD,
        USS_OP_SHR,
        USS_OP_SHL,
        USS_OP_LOAD
    } uss_op_e;
endpackage
`default_nettype wire

// ==== verilog/uss_stream_if.sv ====
// Interface carrying the register-contents stream into the output buffer
`timescale 1ns/10ps
`default_nettype none
interface uss_stream_if
    import uss_pkg::*;
#(
    parameter int unsigned WIDTH = USS_WIDTH
);
    // Data word and handshake
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    // Producer side
    modport src (output data, output valid, input ready);
    // Consumer side
    modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== verilog/uss_skid_buf.sv ====
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module uss_skid_buf
    import uss_pkg::*;
#(
    parameter int unsigned WIDTH = USS_WIDTH,
    parameter int unsigned DEPTH = USS_BUF_DEPTH
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Fill side
    uss_stream_if.dst       in_s,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic             out_valid,
    input  wire logic        out_ready
);
    localparam int unsigned PW = $clog2(DEPTH);
    // ==========================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem_reg [DEPTH];   // Entries
    logic [PW-1:0]    wr_ptr_reg;        // Next write slot
    logic [PW-1:0]    rd_ptr_reg;        // Oldest entry
    logic [PW:0]      count_reg;         // Occupancy
    wire  logic       push;
    wire  logic       pop;
    wire  logic       full;
    wire  logic       empty;
    // Honest flags; ready falls when full so the source stalls
    assign full          = (count_reg == (PW+1)'(DEPTH));
    assign empty         = (count_reg == '0);
    assign in_s.ready    = !full;
    assign push          = in_s.valid && !full;
    assign pop           = !empty && out_ready;
    // Read data straight from the oldest storage entry
    assign out_data      = mem_reg[rd_ptr_reg];
    assign out_valid     = !empty;
    // ==========================================================
    // Entry write; storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_s.data;
        end
    end
    // Pointer and count update
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= PW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= PW'((rd_ptr_reg + 1'b1) % DEPTH);
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== verilog/uss_shift_reg.sv ====
// Universal eight-bit shift/storage register with shared parallel pins
// Function
// - Inputs sampled only on rising clock edge.
// - Async variant: low clear zeroes immediately.
// - Sync variant: low clear zeroes on edge.
// - Both selects low hold contents.
// - Shift toward bit 7 or bit 0.
// - Both selects high load parallel pins.
// - Load mode releases all parallel pins from the next edge.
// - Enables low, not load: drive register.
// - Any enable high releases all pins from the next edge.
// - Pins readable while driver disabled.
`timescale 1ns/10ps
`default_nettype none
module uss_shift_reg
    import uss_pkg::*;
#(
    parameter int unsigned WIDTH     = USS_WIDTH,
    parameter logic        SYNC_CLR  = USS_VARIANT_ASYNC
) (
    // Clock
    input  wire logic             clk,
    // Chip reset and master clear
    input  wire logic             rst_b,
    input  wire logic             master_clear_n,
    // Mode selects
    input  wire logic             mode_select_low,
    input  wire logic             mode_select_high,
    // Serial inputs
    input  wire logic             serial_in_low_end,
    input  wire logic             serial_in_high_end,
    // Parallel pin drive enables, active low
    input  wire logic             port_drive_enable_a_n,
    input  wire logic             port_drive_enable_b_n,
    // Shared parallel pins split into in, out, enable
    input  wire logic [WIDTH-1:0] shared_parallel_pins_i,
    output logic [WIDTH-1:0]      shared_parallel_pins_o,
    output logic [WIDTH-1:0]      shared_parallel_pins_oe,
    // Serial end outputs
    output logic                  serial_out_low_end,
    output logic                  serial_out_high_end,
    // Buffered stream of the next contents at each shift or load edge unless an offer is stalled; clears are not sent
    output logic [WIDTH-1:0]      snap_data,
    output logic                  snap_valid,
    input  wire logic             snap_ready,
    // Stall flag: a change could not be queued
    output logic                  snap_stall
);
    // ==========================================================
    // Decode
    logic [WIDTH-1:0] q_reg;            // Register contents
    logic [WIDTH-1:0] q_next;           // Next contents
    logic             clr_async_n;      // Reset seen by the register and pin flops
    wire  logic [1:0] mode_sel;         // Packed selects
    wire  logic       is_load;          // Both selects high
    wire  logic       drive_ok;         // Both enables asserted
    wire  logic       drive_on;         // Pins driven after the next edge
    uss_op_e          op;               // Decoded operation
    wire  logic [WIDTH-1:0] shr_val;    // Shift toward bit 7
    wire  logic [WIDTH-1:0] shl_val;    // Shift toward bit 0
    wire  logic       sync_clr;         // Clocked clear request

    assign mode_sel = {mode_select_high, mode_select_low};
    assign op       = uss_op_e'(mode_sel);
    assign is_load  = (mode_sel == USS_MODE_LOAD);
    assign drive_ok = !port_drive_enable_a_n && !port_drive_enable_b_n;
    assign drive_on = drive_ok && !is_load;

    assign shr_val  = {q_reg[WIDTH-2:0], serial_in_low_end};
    assign shl_val  = {serial_in_high_end, q_reg[WIDTH-1:1]};

    // The async variant folds the master clear into the flop reset;
    // a glitch on master_clear_n then clears at once, as intended
    // clear overrides every mode of the register and pin data
    assign clr_async_n = (SYNC_CLR == USS_VARIANT_ASYNC) ? (rst_b && master_clear_n) : rst_b;
    assign sync_clr    = (SYNC_CLR == USS_VARIANT_SYNC) && !master_clear_n;

    // ==========================================================
    // Next-state selection
    always_comb begin
        case (op)
            USS_OP_HOLD: q_next = q_reg;
            USS_OP_SHR:  q_next = shr_val;
            USS_OP_SHL:  q_next = shl_val;
            // pin input path read even when undriven
            USS_OP_LOAD: q_next = shared_parallel_pins_i;
            default:     q_next = q_reg;
        endcase
    end

    // ==========================================================
    // Register; changes only on the rising edge or async clear
    // sampled on rising edge only
    always_ff @(posedge clk or negedge clr_async_n) begin
        if (!clr_async_n) begin
            q_reg <= USS_CLEAR_VAL;
        end else if (sync_clr) begin
            q_reg <= USS_CLEAR_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    // ==========================================================
    // Pin drivers. Outputs must come from flops, so the pin value and
    // enable are registered from next-cycle values; this matches the
    // register contents exactly but the enable reacts one edge late.
    logic [WIDTH-1:0] pin_o_reg;        // Registered pin data
    logic             pin_oe_reg;       // Registered drive enable
    always_ff @(posedge clk or negedge clr_async_n) begin
        if (!clr_async_n) begin
            pin_o_reg  <= USS_CLEAR_VAL;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_o_reg  <= sync_clr ? USS_CLEAR_VAL : q_next;
            pin_oe_reg <= drive_on;
        end
    end
    assign shared_parallel_pins_o  = pin_o_reg;
    assign shared_parallel_pins_oe = {WIDTH{pin_oe_reg}};

    assign serial_out_low_end  = q_reg[USS_LOW_BIT];
    assign serial_out_high_end = q_reg[USS_HIGH_BIT];

    // ==========================================================
    // Change stream into the two-entry buffer
    uss_stream_if #(.WIDTH(WIDTH)) snap_if ();
    logic [WIDTH-1:0] snap_word_reg;    // Word offered to buffer
    logic             snap_vld_reg;     // Offer pending
    logic             stall_reg;        // Lost-change flag
    wire  logic       changed;          // Shift or load this edge without a clocked clear
    assign changed      = !sync_clr && (op != USS_OP_HOLD);
    assign snap_if.data = snap_word_reg;
    assign snap_if.valid = snap_vld_reg;
    // Holds an offer until taken; a change during a stall sets the flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            snap_word_reg <= USS_CLEAR_VAL;
            snap_vld_reg  <= 1'b0;
            stall_reg     <= 1'b0;
        end else begin
            if (!snap_vld_reg || snap_if.ready) begin
                snap_vld_reg  <= changed;
                snap_word_reg <= q_next;
            end else if (changed) begin
                stall_reg <= 1'b1;
            end
        end
    end
    assign snap_stall = stall_reg;

    uss_skid_buf #(.WIDTH(WIDTH), .DEPTH(USS_BUF_DEPTH)) u_buf (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_s      (snap_if),
        .out_data  (snap_data),
        .out_valid (snap_valid),
        .out_ready (snap_ready)
    );
endmodule
`default_nettype wire

// ==== sim/uss_shift_reg_monitor.sv ====
// Concurrent checks on the shift register ports
`timescale 1ns/10ps
`default_nettype none
module uss_shift_reg_chk
    import uss_pkg::*;
(
    // Clock and clears
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       master_clear_n,
    // Controls
    input wire logic       mode_select_low,
    input wire logic       mode_select_high,
    input wire logic       serial_in_low_end,
    input wire logic       serial_in_high_end,
    input wire logic       port_drive_enable_a_n,
    input wire logic       port_drive_enable_b_n,
    // Pins and register ends
    input wire logic [7:0] shared_parallel_pins_i,
    input wire logic [7:0] shared_parallel_pins_o,
    input wire logic [7:0] shared_parallel_pins_oe,
    input wire logic       serial_out_low_end,
    input wire logic       serial_out_high_end
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic [1:0] md = {mode_select_high, mode_select_low};
    // One clocked step with the clear released on both sides
    sequence s_step(logic [1:0] m);
        master_clear_n && md == m ##1 master_clear_n;
    endsequence
    AST_HOLD: assert property (s_step(USS_MODE_HOLD) |-> $stable(shared_parallel_pins_o)) else $error("hold moved");
    AST_SHR: assert property (s_step(USS_MODE_SHR) |-> shared_parallel_pins_o ==
        {$past(shared_parallel_pins_o[6:0]), $past(serial_in_low_end)}) else $error("shift to bit7 wrong");
    AST_SHL: assert property (s_step(USS_MODE_SHL) |-> shared_parallel_pins_o ==
        {$past(serial_in_high_end), $past(shared_parallel_pins_o[7:1])}) else $error("shift to bit0 wrong");
    AST_LOAD: assert property (s_step(USS_MODE_LOAD) |->
        shared_parallel_pins_o == $past(shared_parallel_pins_i)) else $error("load wrong");
    AST_OE: assert property ($past(rst_b) && $past(master_clear_n) && master_clear_n |->
        shared_parallel_pins_oe == {8{$past(!port_drive_enable_a_n && !port_drive_enable_b_n && md != USS_MODE_LOAD)}})
        else $error("pin drive wrong");
    AST_DIS: assert property (port_drive_enable_a_n || port_drive_enable_b_n |=>
        shared_parallel_pins_oe == 8'h00) else $error("pins driven while disabled");
    AST_ENDS: assert property (serial_out_low_end == shared_parallel_pins_o[0] &&
        serial_out_high_end == shared_parallel_pins_o[7]) else $error("end bits wrong");
    AST_CLR: assert property (!master_clear_n |-> shared_parallel_pins_o == 8'h00) else $error("clear missed");
endmodule
bind uss_shift_reg uss_shift_reg_chk u_chk (.clk(clk), .rst_b(rst_b), .master_clear_n(master_clear_n),
    .mode_select_low(mode_select_low), .mode_select_high(mode_select_high), .serial_in_low_end(serial_in_low_end),
    .serial_in_high_end(serial_in_high_end), .port_drive_enable_a_n(port_drive_enable_a_n),
    .port_drive_enable_b_n(port_drive_enable_b_n), .shared_parallel_pins_i(shared_parallel_pins_i),
    .shared_parallel_pins_o(shared_parallel_pins_o), .shared_parallel_pins_oe(shared_parallel_pins_oe),
    .serial_out_low_end(serial_out_low_end), .serial_out_high_end(serial_out_high_end));
`default_nettype wire

// ==== sim/uss_pin_partner.sv ====
// Outside logic sharing the parallel pins with the register
`timescale 1ns/10ps
`default_nettype none
module uss_pin_partner (
    // Clock
    input wire logic       clk,
    // Device side of the pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Outside drive
    input wire logic       ext_en,
    input wire logic [7:0] ext_val,
    // Resolved pin levels
    output logic [7:0]     pin_lvl
);
    logic [7:0] last_reg = 8'h00;  // Last level seen
    // No pull on the pins: a floating pin toggles so stale data never passes
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & (ext_en ? ext_val : ~last_reg));
    always @(posedge clk) begin
        last_reg <= pin_lvl;
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the shift register
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import uss_pkg::*;
    logic       clk = 1'b0, rst_b = 1'b0, mcl_n = 1'b1, sl = 1'b0, sh = 1'b0, sil = 1'b0, sih = 1'b0;
    logic       oea_n = 1'b0, oeb_n = 1'b0, ext_en = 1'b0, rdy = 1'b0, sol, soh, sval, sstl;
    logic [7:0] ext_val = 8'h00, lvl, po, poe, sdat;
    int         err_total = 0, tests_run = 0, cyc = 0;
    uss_shift_reg DUT (.clk(clk), .rst_b(rst_b), .master_clear_n(mcl_n), .mode_select_low(sl), .mode_select_high(sh),
        .serial_in_low_end(sil), .serial_in_high_end(sih), .port_drive_enable_a_n(oea_n), .port_drive_enable_b_n(oeb_n),
        .shared_parallel_pins_i(lvl), .shared_parallel_pins_o(po), .shared_parallel_pins_oe(poe),
        .serial_out_low_end(sol), .serial_out_high_end(soh), .snap_data(sdat), .snap_valid(sval),
        .snap_ready(rdy), .snap_stall(sstl));
    uss_pin_partner u_bus (.clk(clk), .pin_out(po), .pin_oe(poe), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(lvl));
    initial forever #4 clk = ~clk;
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One operation on one edge, then back to hold so it is not repeated
    task automatic op(input logic [1:0] m, input logic i0, input logic i7, input logic a, input logic b);
        @(posedge clk);
        {sh, sl} <= m;
        {sil, sih, oea_n, oeb_n} <= {i0, i7, a, b};
        @(posedge clk);
        {sh, sl} <= USS_MODE_HOLD;
        #1;
    endtask
    task automatic t_stream;
        // Release the pins first: the drive enable follows the selects one edge late
        op(USS_MODE_HOLD, 1'b0, 1'b0, 1'b1, 1'b1);
        ext_en = 1'b1;
        ext_val = 8'h11;
        op(USS_MODE_LOAD, 1'b0, 1'b0, 1'b0, 1'b0);
        ext_en = 1'b0;
        repeat (5) op(USS_MODE_SHR, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk({sval, sstl, 6'h0}, 8'hC0);
        chk(sdat, 8'h11);
        @(posedge clk);
        rdy <= 1'b1;
        for (int i = 0; i < 10 && sval !== 1'b0; i++) @(posedge clk);
        #1;
        chk({7'h0, sval}, 8'h00);
    endtask
    task automatic t_modes;
        op(USS_MODE_HOLD, 1'b0, 1'b0, 1'b1, 1'b1);
        ext_en = 1'b1;
        ext_val = 8'hA5;
        op(USS_MODE_LOAD, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(po, 8'hA5);
        chk(poe, 8'h00);
        ext_en = 1'b0;
        op(USS_MODE_SHR, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(po, 8'h4B);
        op(USS_MODE_SHL, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(po, 8'h25);
        chk({6'h0, soh, sol}, 8'h01);
        op(USS_MODE_HOLD, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(po, 8'h25);
        chk(lvl, 8'h25);
    endtask
    task automatic t_oe;
        for (int k = 0; k < 4; k++) begin
            op(USS_MODE_HOLD, 1'b0, 1'b0, k[0], k[1]);
            chk(poe, (k == 0) ? 8'hFF : 8'h00);
        end
    endtask
    task automatic t_recirc;
        ext_en = 1'b1;
        ext_val = 8'h81;
        op(USS_MODE_LOAD, 1'b0, 1'b0, 1'b1, 1'b1);
        chk(po, 8'h81);
        ext_en = 1'b0;
        op(USS_MODE_SHR, soh, 1'b0, 1'b0, 1'b0);
        chk(po, 8'h03);
        repeat (7) op(USS_MODE_SHR, soh, 1'b0, 1'b0, 1'b0);
        chk(po, 8'h81);
    endtask
    task automatic t_clear;
        @(posedge clk);
        mcl_n <= 1'b0;
        #2;
        chk(po, 8'h00);
        @(posedge clk);
        mcl_n <= 1'b1;
        #1;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_stream;
        t_modes;
        t_oe;
        t_recirc;
        t_clear;
        report_and_stop;
    end
endmodule
`default_nettype wire
